//--- hw/aer_pkg.sv
// package: constants and types of the error severity and correctable regs
package aer_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] uncorrectable_error_severity_off = 12'h10c;
    localparam logic [11:0] correctable_error_status_off     = 12'h110;
    localparam logic [11:0] correctable_error_mask_off       = 12'h114;
    localparam logic [11:0] header_log_off                   = 12'h11c;
    localparam logic [11:0] irq_status_off                   = 12'h200;
    localparam logic [11:0] irq_clear_off                    = 12'h204;
    localparam logic [11:0] irq_enable_off                   = 12'h208;

    // ------------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] sev_writable   = 32'h003f_f031;
    localparam logic [31:0] sev_reset      = 32'h0006_2031;
    localparam int          sev_surprise_bit = 5;
    localparam logic [31:0] corr_writable  = 32'h0000_31c1;
    localparam logic [31:0] mask_reset     = 32'h0000_2000;
    localparam logic [31:0] zero_word      = 32'h0000_0000;
    localparam int          corr_events    = 6;
    localparam int          log_words      = 4;
    // correctable bit position of each event input, index 0..5
    localparam int          corr_pos [corr_events] = '{0, 6, 7, 8, 12, 13};
    // interrupt sources: one per correctable event, plus a log capture
    localparam int          irq_bits       = 7;
    localparam logic [6:0]  irq_zero       = 7'h00;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // one-cycle event strobes from the link layer, with header of the tlp
    typedef struct packed {
        logic [corr_events-1:0] event_strobe;
        logic [127:0]           tlp_header;
    } corr_event_t;

    // report toward the message generator
    typedef struct packed {
        logic                   report;
        logic [corr_events-1:0] source;
    } corr_report_t;

endpackage : aer_pkg

//--- hw/aer_regs.sv
// design: severity, correctable status and correctable mask registers
//
// Functional notes
// - severity bits: 0 non-fatal, 1 fatal
// - surprise-down severity only on downstream ports
// - receiver error sets status bit 0
// - bad tlp sets status bit 6
// - bad dllp sets status bit 7
// - replay-number rollover sets status bit 8
// - replay timer timeout sets status bit 12
// - advisory non-fatal sets status bit 13
// - mask 0 blocks receiver error log/message
// - mask 6 blocks bad tlp log/message
// - mask 7 blocks bad dllp log/message
// - mask 8 blocks rollover log/message
// - mask 12 blocks replay timeout log/message
// - mask 13 blocks advisory; resets to one
// - header log: four big-endian words, read-only
`timescale 1ns/1ps
`default_nettype none

module aer_regs
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 clk_en,
    input  wire logic                 downstream_port,
    input  wire aer_pkg::apb_req_t    apb_req,
    output var  aer_pkg::apb_rsp_t    apb_rsp,
    input  wire aer_pkg::corr_event_t corr_event,
    output var  aer_pkg::corr_report_t corr_report,
    output var  logic [31:0]          severity,
    output var  logic                 irq
);
    import aer_pkg::*;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [31:0]            sev_reg;
    logic [31:0]            corr_status;
    logic [31:0]            corr_mask;
    logic [31:0]            header_log [log_words];
    logic                   log_valid;
    logic [irq_bits-1:0]    irq_status;
    logic [irq_bits-1:0]    irq_enable;
    logic [31:0]            event_bits;
    logic [corr_events-1:0] unmasked;
    logic                   wr_en;
    logic                   rd_en;
    logic                   hit;
    logic [31:0]            next_rdata;

    // ------------------------------------------------------------------
    // decode and next-state signals
    // ------------------------------------------------------------------
    logic                   sel_sev;
    logic                   sel_status;
    logic                   sel_mask;
    logic [log_words-1:0]   sel_log;
    logic                   sel_irq_status;
    logic                   sel_irq_clear;
    logic                   sel_irq_enable;
    logic                   wr_sev;
    logic                   wr_status;
    logic                   wr_mask;
    logic                   wr_irq_clear;
    logic                   wr_irq_enable;
    logic                   rearm_log;
    logic                   capture;
    logic [irq_bits-1:0]    irq_set;
    logic [31:0]            next_sev;
    logic [31:0]            next_status;
    logic [31:0]            next_mask;
    logic [irq_bits-1:0]    next_irq_status;
    logic [irq_bits-1:0]    next_irq_enable;

    // ------------------------------------------------------------------
    // apb qualifiers
    // ------------------------------------------------------------------
    // pready follows clk_en, so a frozen block stretches writes and reads set up
    // while clk_en is high; a read set up while frozen returns stale prdata
    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & clk_en;
    assign rd_en = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite
                   & clk_en;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // one select per word, shared by writes, the log re-arm and the error flag;
    // reads decode the same words in their own case, so a word that answers without error is exactly a word that exists
    assign sel_sev        = apb_req.paddr == uncorrectable_error_severity_off;
    assign sel_status     = apb_req.paddr == correctable_error_status_off;
    assign sel_mask       = apb_req.paddr == correctable_error_mask_off;
    assign sel_irq_status = apb_req.paddr == irq_status_off;
    assign sel_irq_clear  = apb_req.paddr == irq_clear_off;
    assign sel_irq_enable = apb_req.paddr == irq_enable_off;

    genvar gl;
    generate
        for (gl = 0; gl < log_words; gl++)
        begin : g_log_sel
            assign sel_log[gl] = apb_req.paddr
                                 == header_log_off + 12'(4 * gl);
        end
    endgenerate

    assign hit = sel_sev | sel_status | sel_mask | (|sel_log)
                 | sel_irq_status | sel_irq_clear | sel_irq_enable;

    // ------------------------------------------------------------------
    // access strobes
    // ------------------------------------------------------------------
    // writes land in the access cycle; the log re-arm rides on the setup
    // of a read of the last header word, the cycle its data is latched
    assign wr_sev        = wr_en & sel_sev;
    assign wr_status     = wr_en & sel_status;
    assign wr_mask       = wr_en & sel_mask;
    assign wr_irq_clear  = wr_en & sel_irq_clear;
    assign wr_irq_enable = wr_en & sel_irq_enable;
    assign rearm_log     = rd_en & sel_log[log_words-1];

    // ------------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < corr_events; gi++)
        begin : g_evt
            // status set is independent of the mask
            assign unmasked[gi] = corr_event.event_strobe[gi]
                                  & ~corr_mask[corr_pos[gi]];
        end
    endgenerate

    always_comb
    begin
        event_bits = zero_word;
        for (int i = 0; i < corr_events; i++)
        begin
            event_bits[corr_pos[i]] = corr_event.event_strobe[i];
        end
    end

    // a capture needs an unmasked event and a free log; masked events and
    // events that find the log busy still reach status and interrupt
    assign capture = |unmasked & ~log_valid;
    assign irq_set = {capture, corr_event.event_strobe};

    // ------------------------------------------------------------------
    // next register values
    // ------------------------------------------------------------------
    // the clear term is applied before the set term, so an event that
    // meets its own write-one-to-clear in one cycle leaves the bit set
    always_comb
    begin
        next_sev        = sev_reg;
        next_status     = corr_status | event_bits;
        next_mask       = corr_mask;
        next_irq_status = irq_status | irq_set;
        next_irq_enable = irq_enable;
        if (wr_sev)
            next_sev = apb_req.pwdata & sev_writable;
        if (wr_status)
            next_status = (corr_status & ~apb_req.pwdata) | event_bits;
        if (wr_mask)
            next_mask = apb_req.pwdata & corr_writable;
        if (wr_irq_clear)
            next_irq_status = (irq_status & ~apb_req.pwdata[irq_bits-1:0])
                              | irq_set;
        if (wr_irq_enable)
            next_irq_enable = apb_req.pwdata[irq_bits-1:0];
        next_status = next_status & corr_writable;
    end

    // ------------------------------------------------------------------
    // severity register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sev_reg <= sev_reset;
        end
        else if (clk_en)
        begin
            sev_reg <= next_sev;
        end
    end

    // surprise-down class is meaningless upstream, so it reads as set only
    // where it can apply; software still reads back what it wrote
    always_comb
    begin
        severity = sev_reg;
        if (!downstream_port)
            severity[sev_surprise_bit] = 1'b0;
    end

    // ------------------------------------------------------------------
    // correctable status
    // ------------------------------------------------------------------
    // sticky flags: only reset or a write of one clears them
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            corr_status <= zero_word;
        end
        else if (clk_en)
        begin
            corr_status <= next_status;
        end
    end

    // ------------------------------------------------------------------
    // correctable mask
    // ------------------------------------------------------------------
    // the advisory mask starts set, so advisory errors are neither logged nor
    // reported until software opts in
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            corr_mask <= mask_reset;
        end
        else if (clk_en)
        begin
            corr_mask <= next_mask;
        end
    end

    // ------------------------------------------------------------------
    // header log
    // ------------------------------------------------------------------
    // first unmasked error wins; later ones are not logged until software
    // has read the last header word, so one slow reader loses headers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            log_valid <= 1'b0;
            for (int i = 0; i < log_words; i++)
            begin
                header_log[i] <= zero_word;
            end
        end
        else if (clk_en)
        begin
            if (capture)
            begin
                log_valid <= 1'b1;
                for (int i = 0; i < log_words; i++)
                begin
                    header_log[i] <= corr_event.tlp_header[
                        127-32*i -: 32];
                end
            end
            else if (rearm_log)
                log_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // error report
    // ------------------------------------------------------------------
    // one pulse per cycle with unmasked events; the message side splits it into
    // one message per source
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            corr_report <= '0;
        else if (clk_en)
        begin
            corr_report.report <= |unmasked;
            corr_report.source <= unmasked;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------------
    // bits 5:0 follow the raw event strobes, masked or not, and bit 6
    // marks a header capture; masking therefore does not hide an event
    // from the local interrupt, only from the log and the message
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            irq_status <= irq_zero;
        end
        else if (clk_en)
        begin
            irq_status <= next_irq_status;
        end
    end

    // ------------------------------------------------------------------
    // interrupt enable
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            irq_enable <= irq_zero;
        end
        else if (clk_en)
        begin
            irq_enable <= next_irq_enable;
        end
    end

    assign irq = |(irq_status & irq_enable);

    // ------------------------------------------------------------------
    // apb read path
    // ------------------------------------------------------------------
    // data is latched in the setup cycle, so it stands still for the
    // whole access however long clk_en stretches it
    always_comb
    begin
        next_rdata = zero_word;
        unique case (apb_req.paddr)
            uncorrectable_error_severity_off: next_rdata = sev_reg;
            correctable_error_status_off:     next_rdata = corr_status;
            correctable_error_mask_off:       next_rdata = corr_mask;
            header_log_off:                   next_rdata = header_log[0];
            header_log_off + 12'h004:         next_rdata = header_log[1];
            header_log_off + 12'h008:         next_rdata = header_log[2];
            header_log_off + 12'h00c:         next_rdata = header_log[3];
            irq_status_off:    next_rdata = {25'h0000000, irq_status};
            irq_enable_off:    next_rdata = {25'h0000000, irq_enable};
            irq_clear_off:     next_rdata = zero_word;
            default:           next_rdata = zero_word;
        endcase
    end

    // ------------------------------------------------------------------
    // apb response
    // ------------------------------------------------------------------

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            apb_rsp.prdata  <= zero_word;
            apb_rsp.pslverr <= 1'b0;
        end
        else if (clk_en && apb_req.psel && !apb_req.penable)
        begin
            apb_rsp.prdata  <= apb_req.pwrite ? zero_word : next_rdata;
            apb_rsp.pslverr <= ~hit;
        end
    end

    assign apb_rsp.pready = clk_en;

endmodule : aer_regs

`default_nettype wire

//--- tb/aer_regs_assertions.sv
// checker: port-level assertions of the error register block
`timescale 1ns/1ps
`default_nettype none
module aer_regs_assertions
(
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire logic                  clk_en,
    input wire logic                  downstream_port,
    input wire aer_pkg::apb_req_t     apb_req,
    input wire aer_pkg::apb_rsp_t     apb_rsp,
    input wire aer_pkg::corr_event_t  corr_event,
    input wire aer_pkg::corr_report_t corr_report,
    input wire logic [31:0]           severity,
    input wire logic                  irq
);
    import aer_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence sev_write;
        apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready
            && apb_req.paddr == uncorrectable_error_severity_off;
    endsequence
    sequence bad_setup;
        clk_en && apb_req.psel && !apb_req.penable && apb_req.paddr > 12'h208;
    endsequence
    sev_write_a: assert property (sev_write |=> severity ==
        ($past(apb_req.pwdata) & sev_writable
        & (downstream_port ? 32'hffffffff : 32'hffffffdf)))
        else $error("severity write mismatch");
    sev_resv_a: assert property (
        (severity & ~sev_writable) == zero_word)
        else $error("severity reserved bit set");
    surprise_up_a: assert property (!downstream_port |-> !severity[5])
        else $error("surprise bit live upstream");
    rep_cause_a: assert property (corr_report.report |->
        (corr_report.source & ~$past(corr_event.event_strobe)) == 6'h00)
        else $error("report without strobe");
    rep_src_a: assert property (corr_report.report |->
        corr_report.source != 6'h00) else $error("report with no source");
    bad_addr_a: assert property (bad_setup |=> apb_rsp.pslverr
        && apb_rsp.prdata == zero_word) else $error("unmapped not refused");
    good_addr_a: assert property (apb_req.psel && apb_req.penable
        && apb_req.paddr inside {12'h10c, 12'h110, 12'h114}
        |-> !apb_rsp.pslverr) else $error("mapped access refused");
    irq_cause_a: assert property ($rose(irq) |->
        $past(|corr_event.event_strobe) || $past(apb_req.pwrite))
        else $error("irq rose without cause");
endmodule : aer_regs_assertions
bind aer_regs aer_regs_assertions i_chk (.ref_clk(ref_clk), .rst(rst),
    .clk_en(clk_en), .downstream_port(downstream_port), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .corr_event(corr_event), .corr_report(corr_report),
    .severity(severity), .irq(irq));
`default_nettype wire

//--- tb/aer_msg_sink.sv
// partner: root complex side, counts correctable error messages
`timescale 1ns/1ps
`default_nettype none
module aer_msg_sink
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire aer_pkg::corr_report_t corr_report,
    output var  logic [7:0]            msg_count
);
    import aer_pkg::*;
    // one message per reported source, as if each were sent separately
    always_ff @(posedge ref_clk)
        if (rst)
            msg_count <= 8'h00;
        else if (corr_report.report)
            msg_count <= msg_count + 8'($countones(corr_report.source));
endmodule : aer_msg_sink
`default_nettype wire

//--- tb/pcie_error_severity_correctable_regs_tb.sv
// testbench: registers, events, masks, header log and interrupt
`timescale 1ns/1ps
`default_nettype none
module pcie_error_severity_correctable_regs_tb;
    import aer_pkg::*;
    logic         ref_clk = 1'b0;
    logic         rst = 1'b1;
    logic         dsp = 1'b1;
    logic         en = 1'b1;
    apb_req_t     req = '0;
    apb_rsp_t     rsp;
    corr_event_t  ce = '0;
    corr_report_t rep;
    logic [31:0]  sev;
    logic         irq;
    logic [7:0]   msg_count;
    logic [31:0]  exp_q[$];
    logic [127:0] hdr[6];
    integer       seed = 32'hcf0ff8cb;
    logic [31:0]  d;
    int           num_errors = 0;
    int           checks_done = 0;
    always #10 ref_clk = ~ref_clk;
    aer_regs i_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(en),
        .downstream_port(dsp), .apb_req(req), .apb_rsp(rsp),
        .corr_event(ce), .corr_report(rep), .severity(sev), .irq(irq));
    aer_msg_sink i_rc (.ref_clk(ref_clk), .rst(rst), .corr_report(rep),
        .msg_count(msg_count));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, w, a, wd};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do @(posedge ref_clk); while (rsp.pready !== 1'b1);
        req <= '0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic ev(input int i);
        @(posedge ref_clk);
        ce <= '{6'(1 << i), hdr[i]};
        @(posedge ref_clk);
        ce.event_strobe <= 6'h00;
        repeat (3) @(posedge ref_clk);
    endtask : ev
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    // read results are compared by this watcher, oldest note first
    always @(posedge ref_clk)
        if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1)
            chk(rsp.prdata, exp_q.pop_front());
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        num_errors++;
        final_report();
    end
    initial
    begin
        foreach (hdr[k])
            hdr[k] = {$random(seed), $random(seed), $random(seed),
                      $random(seed)};
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd(uncorrectable_error_severity_off, sev_reset);
        chk(sev, sev_reset);
        rd(correctable_error_status_off, zero_word);
        rd(correctable_error_mask_off, mask_reset);
        dsp <= 1'b0;
        @(posedge ref_clk);
        chk(sev, 32'h0006_2011);
        dsp <= 1'b1;
        repeat (3)
        begin
            d = $random(seed);
            apb(1'b1, uncorrectable_error_severity_off, d);
            rd(uncorrectable_error_severity_off, d & sev_writable);
        end
        apb(1'b1, 12'h300, d);
        rd(12'h300, zero_word);
        apb(1'b1, correctable_error_mask_off, 32'hffffffff);
        rd(correctable_error_mask_off, corr_writable);
        apb(1'b1, correctable_error_mask_off, zero_word);
        $display("test registers done");
        for (int i = 0; i < corr_events; i++)
        begin
            ev(i);
            chk({24'h0, msg_count}, 32'(i + 1));
        end
        rd(correctable_error_status_off, corr_writable);
        for (int k = 0; k < log_words; k++)
            rd(header_log_off + 12'(4 * k),
               hdr[0][127 - 32 * k -: 32]);
        apb(1'b1, irq_enable_off, 32'h40);
        @(posedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, irq_clear_off, 32'h7f);
        @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, correctable_error_status_off, 32'hffffffff);
        rd(correctable_error_status_off, zero_word);
        $display("test events done");
        apb(1'b1, correctable_error_mask_off, corr_writable);
        apb(1'b1, irq_enable_off, 32'h01);
        for (int i = 0; i < corr_events; i++)
            ev(i);
        chk({24'h0, msg_count}, 32'h6);
        rd(correctable_error_status_off, corr_writable);
        chk({31'h0, irq}, 32'h1);
        $display("test masks done");
        apb(1'b1, correctable_error_status_off, 32'hffffffff);
        @(posedge ref_clk);
        en <= 1'b0;
        ce <= '{6'h01, hdr[5]};
        @(posedge ref_clk);
        ce.event_strobe <= 6'h00;
        chk({31'h0, rsp.pready}, 32'h0);
        repeat (2) @(posedge ref_clk);
        en <= 1'b1;
        rd(correctable_error_status_off, zero_word);
        $display("test freeze done");
        final_report();
    end
endmodule : pcie_error_severity_correctable_regs_tb
`default_nettype wire
